/* File: testbench/wdt_reset_ctrl_bench.sv */
// self-checking bench for the watchdog and reset control block
`timescale 1ns/1ps

module wdt_reset_ctrl_bench;
  import wdt_rst_pkg::*;

  // ==========================================================================
  // stimulus and observation signals
  // ==========================================================================
  logic              clk        = 1'b0;
  logic              rst        = 1'b1;
  logic              psel       = 1'b0;
  logic              penable    = 1'b0;
  logic              pwrite     = 1'b0;
  logic [ADDR_W-1:0] paddr      = '0;
  logic [31:0]       pwdata     = '0;
  logic              slow_osc   = 1'b0;
  logic              supply_low = 1'b0;
  logic              clr        = 1'b0;
  logic              halt       = 1'b0;
  logic              pdm        = 1'b0;
  logic [2:0]        div        = '0;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic              pready;
  logic              pslverr;
  logic              err;
  logic              device_reset;
  logic              pc_sp_reset;
  logic              to_flag;
  logic              pd_flag;
  logic [12:0]       restart_pc;
  logic [7:0]        port_data;
  logic [7:0]        port_dir;
  int                error_cnt       = 0;
  int                samples_checked = 0;
  int                cyc             = 0;
  int                dev_cnt         = 0;
  int                pcsp_cnt        = 0;
  int                n0              = 0;
  int                p0              = 0;

  // small delay count keeps the illegal-code cases short
  wdt_reset_ctrl #(.SRESET_COUNT(2)) u_wdt_reset_ctrl (
    .clk                    (clk),
    .rst                    (rst),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .slow_osc               (slow_osc),
    .supply_low             (supply_low),
    .clear_wdt_instr        (clr),
    .halt_instr             (halt),
    .power_down_mode        (pdm),
    .device_reset           (device_reset),
    .pc_sp_reset            (pc_sp_reset),
    .restart_pc             (restart_pc),
    .port_data              (port_data),
    .port_dir               (port_dir),
    .timeout_status_flag    (to_flag),
    .power_down_status_flag (pd_flag)
  );

  // ==========================================================================
  // clocks, pulse counters and hang guard
  // ==========================================================================
  always #20 clk = ~clk;

  // slow oscillator: one tick every eight core cycles
  always @(posedge clk) begin
    div <= div + 3'h1;
    slow_osc <= div[2];
    cyc <= cyc + 1;
    if (!rst && device_reset === 1'b1) dev_cnt <= dev_cnt + 1;
    if (!rst && pc_sp_reset === 1'b1) pcsp_cnt <= pcsp_cnt + 1;
    if (cyc == 90000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait count assumed here; only the cycle ceiling ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n * 8) @(posedge clk);
  endtask

  // compares full resets and pc-only resets since the last call
  task automatic resets(input int d, input int p);
    check(32'(dev_cnt - n0), 32'(d));
    check(32'(pcsp_cnt - p0), 32'(p));
    n0 = dev_cnt;
    p0 = pcsp_cnt;
  endtask

  task automatic pulse_clear;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // test sequence
  // ==========================================================================
  logic [7:0] thr_codes [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0};
  int         widths    [4] = '{8, 32, 64, 128};
  int         periods   [3] = '{256, 1024, 4096};

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'(restart_pc), 32'h0);
    check({16'h0, port_data, port_dir}, 32'h0000ffff);
    check({30'h0, to_flag, pd_flag}, 32'h0);
    rdchk(OFF_WD_CTRL, 32'h53);
    rdchk(OFF_THR_SEL, 32'h66);
    rdchk(OFF_DROP_WIDTH, 32'h1);
    xfer(1'b1, OFF_RESET_CAUSE, 32'hff);
    rdchk(OFF_RESET_CAUSE, 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // overflow at the three shortest periods, silent just before it
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, OFF_WD_CTRL, {24'h0, KEY_ENABLE, 3'(i)});
      pulse_clear();
      n0 = dev_cnt;
      p0 = pcsp_cnt;
      ticks(periods[i] - 8);
      resets(0, 0);
      ticks(16);
      resets(1, 0);
      check({30'h0, to_flag, pd_flag}, 32'h2);
      rdchk(OFF_PWR_STATUS, 32'h2);
    end
    xfer(1'b1, OFF_WD_CTRL, 32'h50);
    pulse_clear();
    check({30'h0, to_flag, pd_flag}, 32'h0);
    n0 = dev_cnt;
    for (int i = 0; i < 3; i++) begin
      ticks(200);
      pulse_clear();
    end
    ticks(200);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    ticks(200);
    resets(0, 0);
    check({30'h0, to_flag, pd_flag}, 32'h1);
    xfer(1'b1, OFF_WD_CTRL, 32'ha8);
    pulse_clear();
    ticks(300);
    resets(0, 0);
    rdchk(OFF_WD_CTRL, 32'ha8);
    // time-out in sleep with the supply low: pc-only reset, no drop reset
    xfer(1'b1, OFF_WD_CTRL, 32'h50);
    pulse_clear();
    pdm <= 1'b1;
    supply_low <= 1'b1;
    ticks(270);
    resets(0, 1);
    check({30'h0, to_flag, pd_flag}, 32'h3);
    pdm <= 1'b0;
    supply_low <= 1'b0;
    // illegal key
    xfer(1'b1, OFF_WD_CTRL, 32'hf8);
    ticks(8);
    resets(1, 0);
    rdchk(OFF_WD_CTRL, 32'h53);
    rdchk(OFF_RESET_CAUSE, 32'h1);
    xfer(1'b1, OFF_RESET_CAUSE, 32'h7);
    rdchk(OFF_RESET_CAUSE, 32'h1);
    xfer(1'b1, OFF_RESET_CAUSE, 32'h0);
    rdchk(OFF_RESET_CAUSE, 32'h0);
    xfer(1'b1, OFF_WD_CTRL, 32'ha8);
    // every valid threshold code is quiet, a corrupt one resets and restores
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, OFF_THR_SEL, {24'h0, thr_codes[i]});
      ticks(6);
      rdchk(OFF_THR_SEL, {24'h0, thr_codes[i]});
    end
    resets(0, 0);
    xfer(1'b1, OFF_THR_SEL, 32'h12);
    ticks(8);
    resets(1, 0);
    rdchk(OFF_THR_SEL, 32'h66);
    rdchk(OFF_RESET_CAUSE, 32'h2);
    xfer(1'b1, OFF_RESET_CAUSE, 32'h0);
    // drop filter: short episode ignored, longer one resets, per width code
    for (int w = 0; w < 4; w++) begin
      xfer(1'b1, OFF_DROP_WIDTH, 32'(w));
      supply_low <= 1'b1;
      ticks(widths[w] - 3);
      supply_low <= 1'b0;
      ticks(2);
      resets(0, 0);
      supply_low <= 1'b1;
      ticks(widths[w] + 3);
      supply_low <= 1'b0;
      ticks(2);
      resets(1, 0);
    end
    rdchk(OFF_RESET_CAUSE, 32'h4);
    finish_test();
  end

endmodule // wdt_reset_ctrl_bench

/* File: verilog/wdt_reset_ctrl.sv */
// watchdog timer, supply drop filter and reset cause logic with apb registers
//
// Function
// - key reset flag set by illegal-key reset; only a software zero write clears it.
// - upper five bits of the reset cause register always read zero.
// - watchdog overflow while enabled resets the device.
// - key 10101b disables the watchdog, key 01010b enables it.
// - any other key value resets the device after the software reset delay.
// - power-on loads the enable key so the watchdog runs by default.
// - time-out in normal running resets the device and sets the time-out flag.
// - time-out in sleep or idle sets both flags, resets only pc and stack.
// - counter cleared by illegal key, clear instruction or halt instruction.
// - watchdog period spans 2^8 up to 2^18 slow oscillator periods.
// - the program counter restarts at zero after power-on.
// - power-on sets all port data and direction bits to one.
// - supply drop reset always active in fast or slow running modes.
// - supply drop resets only if it lasts longer than the selected width.
// - supply drop reset sets the supply drop reset flag.
// - two-bit drop width select chooses the minimum drop width.
// - supply drop reset inhibited during sleep or idle.
// - corrupted threshold code resets after the delay and sets its flag.
// - threshold select register holds 01100110b after power-on.
// - every valid threshold code selects the same fixed trip level.
// - width codes 00..11 select 8, 32, 64 and 128 slow periods.
// - only six threshold codes valid; others reset, restore power-on value, flag.
// - period codes 000..111 select 2^8,10,12,14,15,16,17,18 slow periods.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

module wdt_reset_ctrl
  import wdt_rst_pkg::*;
#(
  parameter int unsigned PORT_W       = 8,
  parameter int unsigned PC_W         = 13,
  parameter int unsigned SRESET_COUNT = SRESET_TICKS
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              slow_osc,
  input  wire logic              supply_low,
  input  wire logic              clear_wdt_instr,
  input  wire logic              halt_instr,
  input  wire logic              power_down_mode,
  output logic                   device_reset,
  output logic                   pc_sp_reset,
  output logic      [PC_W-1:0]   restart_pc,
  output logic      [PORT_W-1:0] port_data,
  output logic      [PORT_W-1:0] port_dir,
  output logic                   timeout_status_flag,
  output logic                   power_down_status_flag
);

  localparam logic [7:0] SR_LAST = 8'(SRESET_COUNT - 1);

  // ==========================================================================
  // slow oscillator crossing
  // ==========================================================================
  // the oscillator level is resynchronised; the second and third stages feed the edge detect
  logic slow_s1_q, slow_s2_q, slow_s3_q;
  logic slow_tick;

  always_ff @(posedge clk) begin
    if (rst) begin
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      slow_s3_q <= 1'b0;
    end else begin
      slow_s1_q <= slow_osc;
      slow_s2_q <= slow_s1_q;
      slow_s3_q <= slow_s2_q;
    end
  end

  assign slow_tick = slow_s2_q & ~slow_s3_q;

  // ==========================================================================
  // apb slave: one wait state so read data leaves a flip-flop
  // ==========================================================================
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        access_done, mapped;

  logic [7:0]          wd_ctrl_q, wd_ctrl_d;
  logic [7:0]          thr_q, thr_d;
  logic [1:0]          width_q, width_d;
  reset_cause_t        cause_q, cause_d;
  power_status_t       stat_q, stat_d;
  logic [PORT_W-1:0]   port_data_q, port_data_d;
  logic [PORT_W-1:0]   port_dir_q, port_dir_d;

  assign access_done = psel & penable & pready_q;

  always_comb begin
    mapped = 1'b1;
    prdata_d = 32'h0000_0000;
    case (paddr)
      OFF_WD_CTRL:     prdata_d[7:0] = wd_ctrl_q;
      OFF_THR_SEL:     prdata_d[7:0] = thr_q;
      OFF_DROP_WIDTH:  prdata_d[1:0] = width_q;
      OFF_RESET_CAUSE: prdata_d[2:0] = cause_q;
      OFF_PWR_STATUS:  prdata_d[1:0] = stat_q;
      OFF_PORT_DATA:   prdata_d[PORT_W-1:0] = port_data_q;
      OFF_PORT_DIR:    prdata_d[PORT_W-1:0] = port_dir_q;
      default:         mapped = 1'b0;
    endcase
    pready_d = psel & penable & ~pready_q;
    pslverr_d = pready_d & ~mapped;
    if (!pready_d) begin
      prdata_d = prdata_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ==========================================================================
  // watchdog, supply drop filter, software reset delay and flags
  // ==========================================================================
  logic [WD_CNT_W-1:0] wd_cnt_q, wd_cnt_d;
  logic [7:0]          drop_cnt_q, drop_cnt_d;
  logic [7:0]          sr_cnt_q, sr_cnt_d;
  sreset_state_t       sr_q, sr_d;
  logic                dev_rst_q, dev_rst_d;
  logic                pcsp_q, pcsp_d;
  logic                key_bad, thr_bad, wd_run, wd_clear, wd_over;
  logic                drop_fire, sr_fire, wr_en;
  logic [7:0]          drop_lim;

  assign wr_en = access_done & pwrite & mapped;

  always_comb begin
    case (width_q)
      2'h0: drop_lim = DROP_TICKS_0;
      2'h1: drop_lim = DROP_TICKS_1;
      2'h2: drop_lim = DROP_TICKS_2;
      2'h3: drop_lim = DROP_TICKS_3;
    endcase
  end

  always_comb begin
    wd_ctrl_d   = wd_ctrl_q;
    thr_d       = thr_q;
    width_d     = width_q;
    cause_d     = cause_q;
    stat_d      = stat_q;
    port_data_d = port_data_q;
    port_dir_d  = port_dir_q;
    wd_cnt_d    = wd_cnt_q;
    drop_cnt_d  = drop_cnt_q;
    sr_cnt_d    = sr_cnt_q;
    sr_d        = sr_q;
    wd_over     = 1'b0;
    drop_fire   = 1'b0;
    sr_fire     = 1'b0;

    // software writes; flags only accept a clear, hardware sets come later and win
    if (wr_en) begin
      unique case (paddr)
        OFF_WD_CTRL:    wd_ctrl_d = pwdata[7:0];
        OFF_THR_SEL:    thr_d = pwdata[7:0];
        OFF_DROP_WIDTH: width_d = pwdata[1:0];
        OFF_RESET_CAUSE: begin
          if (!pwdata[CAUSE_KEY_BIT]) cause_d.watchdog_key_reset_flag = 1'b0;
          if (!pwdata[CAUSE_THR_BIT]) cause_d.threshold_corrupt_reset_flag = 1'b0;
          if (!pwdata[CAUSE_DROP_BIT]) cause_d.supply_drop_reset_flag = 1'b0;
        end
        OFF_PORT_DATA:  port_data_d = pwdata[PORT_W-1:0];
        OFF_PORT_DIR:   port_dir_d = pwdata[PORT_W-1:0];
        default: begin
        end
      endcase
    end

    key_bad = (wd_ctrl_q[7:KEY_LSB] != KEY_ENABLE) && (wd_ctrl_q[7:KEY_LSB] != KEY_DISABLE);
    thr_bad = !(thr_q inside {THR_CODE_A, THR_CODE_B, THR_CODE_C,
                              THR_CODE_D, THR_CODE_E, THR_CODE_F});
    wd_run  = wd_ctrl_q[7:KEY_LSB] == KEY_ENABLE;

    // watchdog counter
    wd_clear = clear_wdt_instr | halt_instr | key_bad | dev_rst_q;
    if (wd_clear) begin
      wd_cnt_d = '0;
    end else if (wd_run && slow_tick) begin
      if (wd_cnt_q == wd_limit(wd_ctrl_q[2:0])) begin
        wd_over  = 1'b1;
        wd_cnt_d = '0;
      end else begin
        wd_cnt_d = wd_cnt_q + 1'b1;
      end
    end

    // status flags: halt marks power-down, clear instruction clears both
    if (clear_wdt_instr) begin
      stat_d = '0;
    end
    if (halt_instr) begin
      stat_d.power_down_status_flag = 1'b1;
      stat_d.timeout_status_flag    = 1'b0;
    end
    if (wd_over) begin
      stat_d.timeout_status_flag = 1'b1;
      if (power_down_mode) begin
        stat_d.power_down_status_flag = 1'b1;
      end
    end

    // supply drop filter, held off in sleep or idle
    if (power_down_mode || !supply_low) begin
      drop_cnt_d = 8'h00;
    end else if (slow_tick) begin
      if (drop_cnt_q == drop_lim - 8'h01) begin
        drop_fire  = 1'b1;
        drop_cnt_d = 8'h00;
      end else begin
        drop_cnt_d = drop_cnt_q + 8'h01;
      end
    end
    if (drop_fire) begin
      cause_d.supply_drop_reset_flag = 1'b1;
    end

    // software reset delay; once armed it runs out even if the code is repaired
    unique case (sr_q)
      SR_IDLE: begin
        sr_cnt_d = 8'h00;
        if (key_bad && thr_bad) begin
          sr_d = SR_BOTH;
        end else if (key_bad) begin
          sr_d = SR_KEY;
        end else if (thr_bad) begin
          sr_d = SR_THR;
        end
      end
      SR_KEY, SR_THR, SR_BOTH: begin
        if ((sr_q == SR_KEY && thr_bad) || (sr_q == SR_THR && key_bad)) begin
          sr_d = SR_BOTH;
        end
        if (slow_tick) begin
          if (sr_cnt_q == SR_LAST) begin
            sr_fire  = 1'b1;
            sr_cnt_d = 8'h00;
            sr_d     = SR_IDLE;
          end else begin
            sr_cnt_d = sr_cnt_q + 8'h01;
          end
        end
      end
    endcase
    if (sr_fire && sr_q != SR_THR) begin
      cause_d.watchdog_key_reset_flag = 1'b1;
      wd_ctrl_d = WD_CTRL_RESET;
    end
    if (sr_fire && sr_q != SR_KEY) begin
      cause_d.threshold_corrupt_reset_flag = 1'b1;
      thr_d = THR_RESET;
    end

    dev_rst_d = (wd_over & ~power_down_mode) | drop_fire | sr_fire;
    pcsp_d    = wd_over & power_down_mode;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wd_ctrl_q   <= WD_CTRL_RESET;
      thr_q       <= THR_RESET;
      width_q     <= DROP_WIDTH_RESET;
      cause_q     <= '0;
      stat_q      <= '0;
      port_data_q <= '1;
      port_dir_q  <= '1;
      wd_cnt_q    <= '0;
      drop_cnt_q  <= 8'h00;
      sr_cnt_q    <= 8'h00;
      sr_q        <= SR_IDLE;
      dev_rst_q   <= 1'b0;
      pcsp_q      <= 1'b0;
    end else begin
      wd_ctrl_q   <= wd_ctrl_d;
      thr_q       <= thr_d;
      width_q     <= width_d;
      cause_q     <= cause_d;
      stat_q      <= stat_d;
      port_data_q <= port_data_d;
      port_dir_q  <= port_dir_d;
      wd_cnt_q    <= wd_cnt_d;
      drop_cnt_q  <= drop_cnt_d;
      sr_cnt_q    <= sr_cnt_d;
      sr_q        <= sr_d;
      dev_rst_q   <= dev_rst_d;
      pcsp_q      <= pcsp_d;
    end
  end

  // restart vector is a constant zero, kept in a flop so the port starts defined
  logic [PC_W-1:0] restart_pc_q;

  always_ff @(posedge clk) begin
    restart_pc_q <= '0;
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign device_reset           = dev_rst_q;
  assign pc_sp_reset            = pcsp_q;
  assign restart_pc             = restart_pc_q;
  assign port_data              = port_data_q;
  assign port_dir               = port_dir_q;
  assign timeout_status_flag    = stat_q.timeout_status_flag;
  assign power_down_status_flag = stat_q.power_down_status_flag;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_key_fire;
    sr_fire && (sr_q == SR_KEY || sr_q == SR_BOTH);
  endsequence

  sequence s_thr_fire;
    sr_fire && (sr_q == SR_THR || sr_q == SR_BOTH);
  endsequence

  chk_key_flag_clear: assert property (
    $fell(cause_q.watchdog_key_reset_flag) |-> $past(wr_en && paddr == OFF_RESET_CAUSE && !pwdata[0]))
    else $error("key reset flag cleared without a software zero write");

  chk_cause_upper_zero: assert property (
    (access_done && !pwrite && paddr == OFF_RESET_CAUSE) |-> prdata[31:3] == 29'h0)
    else $error("reset cause upper bits not zero");

  chk_wd_normal_reset: assert property (
    (wd_over && !power_down_mode) |=> device_reset && timeout_status_flag && wd_cnt_q == '0)
    else $error("normal time-out did not reset and flag");

  chk_wd_sleep_reset: assert property (
    (wd_over && power_down_mode) |=> pc_sp_reset && !device_reset
                                     && timeout_status_flag && power_down_status_flag)
    else $error("sleep time-out handled wrongly");

  chk_wd_disabled_hold: assert property (
    (wd_ctrl_q[7:3] == KEY_DISABLE && !wd_clear) |=> $stable(wd_cnt_q))
    else $error("disabled watchdog still counts");

  chk_key_fire_effect: assert property (
    s_key_fire |-> $past(sr_q) != SR_IDLE ##1 (device_reset && cause_q.watchdog_key_reset_flag
                                             && wd_ctrl_q == WD_CTRL_RESET))
    else $error("illegal key reset not applied");

  chk_halt_clear: assert property (
    halt_instr |=> wd_cnt_q == '0 && power_down_status_flag && !timeout_status_flag)
    else $error("halt did not clear watchdog");

  chk_drop_width: assert property (
    drop_fire |-> supply_low && !power_down_mode && drop_cnt_q == drop_lim - 8'h01)
    else $error("supply drop fired before its width");

  chk_drop_flag: assert property (
    drop_fire |=> device_reset && cause_q.supply_drop_reset_flag)
    else $error("supply drop reset not flagged");

  chk_drop_sleep_off: assert property (
    power_down_mode |=> drop_cnt_q == 8'h00 && !$rose(cause_q.supply_drop_reset_flag))
    else $error("supply drop filter ran in sleep");

  chk_thr_restore: assert property (
    s_thr_fire |=> thr_q == THR_RESET && cause_q.threshold_corrupt_reset_flag && device_reset)
    else $error("bad threshold code not restored");

endmodule // wdt_reset_ctrl

/* File: verilog/wdt_rst_pkg.sv */
// constants, field layouts and types shared by the watchdog and reset control block
package wdt_rst_pkg;

  // ==========================================================================
  // register map (byte addresses on the apb bus)
  // ==========================================================================
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] OFF_WD_CTRL     = 12'h000;
  localparam logic [11:0] OFF_THR_SEL     = 12'h004;
  localparam logic [11:0] OFF_DROP_WIDTH  = 12'h008;
  localparam logic [11:0] OFF_RESET_CAUSE = 12'h00c;
  localparam logic [11:0] OFF_PWR_STATUS  = 12'h010;
  localparam logic [11:0] OFF_PORT_DATA   = 12'h014;
  localparam logic [11:0] OFF_PORT_DIR    = 12'h018;

  // ==========================================================================
  // field positions and codes
  // ==========================================================================
  localparam int unsigned KEY_LSB         = 3;
  localparam logic [4:0]  KEY_DISABLE     = 5'h15;
  localparam logic [4:0]  KEY_ENABLE      = 5'h0a;
  localparam int unsigned CAUSE_KEY_BIT   = 0;
  localparam int unsigned CAUSE_THR_BIT   = 1;
  localparam int unsigned CAUSE_DROP_BIT  = 2;
  localparam int unsigned STAT_PD_BIT     = 0;
  localparam int unsigned STAT_TO_BIT     = 1;

  // ==========================================================================
  // values after power-on
  // ==========================================================================
  localparam logic [7:0]  WD_CTRL_RESET   = 8'h53;
  localparam logic [7:0]  THR_RESET       = 8'h66;
  localparam logic [1:0]  DROP_WIDTH_RESET = 2'h1;

  // the six accepted threshold codes; all of them pick the one fixed trip level
  localparam logic [7:0]  THR_CODE_A      = 8'h66;
  localparam logic [7:0]  THR_CODE_B      = 8'h55;
  localparam logic [7:0]  THR_CODE_C      = 8'h33;
  localparam logic [7:0]  THR_CODE_D      = 8'h99;
  localparam logic [7:0]  THR_CODE_E      = 8'haa;
  localparam logic [7:0]  THR_CODE_F      = 8'hf0;

  // ==========================================================================
  // counts in slow oscillator periods
  // ==========================================================================
  localparam int unsigned WD_CNT_W        = 18;
  localparam int unsigned SRESET_TICKS    = 16;
  localparam logic [7:0]  DROP_TICKS_0    = 8'h08;
  localparam logic [7:0]  DROP_TICKS_1    = 8'h20;
  localparam logic [7:0]  DROP_TICKS_2    = 8'h40;
  localparam logic [7:0]  DROP_TICKS_3    = 8'h80;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic supply_drop_reset_flag;
    logic threshold_corrupt_reset_flag;
    logic watchdog_key_reset_flag;
  } reset_cause_t;

  typedef struct packed {
    logic timeout_status_flag;
    logic power_down_status_flag;
  } power_status_t;

  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_KEY  = 2'b01,
    SR_THR  = 2'b10,
    SR_BOTH = 2'b11
  } sreset_state_t;

  // last count of the watchdog before it overflows, per period select code
  function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [2:0] sel);
    logic [WD_CNT_W-1:0] lim;
    lim = 18'h000ff;
    case (sel)
      3'h0: lim = 18'h000ff;
      3'h1: lim = 18'h003ff;
      3'h2: lim = 18'h00fff;
      3'h3: lim = 18'h03fff;
      3'h4: lim = 18'h07fff;
      3'h5: lim = 18'h0ffff;
      3'h6: lim = 18'h1ffff;
      3'h7: lim = 18'h3ffff;
    endcase
    return lim;
  endfunction

endpackage
